// ===== design/sar_adc8_conversion_control.sv
// conversion control of the 8-bit successive-approximation converter
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - conversion clock is system clock over field+1
// - gain field drives amplifier gain code
// - unused config bit reads zero, writes ignored
// - enable low holds converter in shutdown
// - normal mode tracks continuously except converting
// - done flag set by hardware, cleared by software
// - busy high while converting, done on fall
// - busy write starts only in software mode
// - timer3, pin edge, timer2 start modes
// - sibling busy write starts in modes 1xx
// - low-power mode tracks three clocks, then converts
// - low-power pin mode tracks while pin low
// - window flag set by hardware, cleared by software
// - each result lands in data register
// - single-ended results and compares are unsigned
// - differential results and compares are signed
// - every result is checked against both limits
// - ordered limits flag results strictly inside
// - conversion takes eight conversion clocks
// - differential pairing selects two's complement output
module sar_adc8_conversion_control
  import sar_adc8_pkg::*;
#(
  parameter int unsigned TRACK_CLOCKS = LP_TRACK_CLKS
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // special function register access
  input  wire sfr_req_s             sfrReq,
  output logic [7:0]                sfrRdData,
  // start sources
  input  wire logic                 timer3Overflow,
  input  wire logic                 timer2Overflow,
  input  wire logic                 siblingBusyWrite,
  input  wire logic                 extConvStart,
  // channel configuration
  input  wire logic [3:0]           channelPairConfig,
  input  wire logic [2:0]           channelSelect,
  // analog core
  input  wire logic                 compAbove,
  output logic [RESULT_BITS-1:0]    sarTrialCode,
  output logic [GAIN_BITS-1:0]      ampGain,
  output logic                      trackEnable,
  output logic                      convActive,
  output logic                      shutdown,
  output logic                      sarConvClock
);

  if (TRACK_CLOCKS < 1 || TRACK_CLOCKS > 15) begin : gChk
    $error("track length must be 1 to 15 conversion clocks");
  end

  // ****************************************
  // register state
  // ****************************************
  logic [DIV_BITS-1:0]    sarClockDivide;
  logic [GAIN_BITS-1:0]   ampGainSelect;
  logic                   converterEnable;
  logic                   trackModeSelect;
  logic                   convDoneFlag;
  logic [MODE_BITS-1:0]   startModeSelect;
  logic                   windowMatchFlag;
  logic [7:0]             conversionResult;
  logic [7:0]             windowGreaterLimit;
  logic [7:0]             windowLessLimit;

  conv_state_e            state;
  conv_state_e            next_state;
  logic [3:0]             trackCnt;
  logic [2:0]             bitPos;
  logic                   extMeta;
  logic                   extSync;
  logic                   extPrev;
  logic                   extRise;
  logic                   trigger;
  logic                   busy;
  logic                   sarTick;
  logic                   convFinish;
  logic                   diffSel;
  logic [7:0]             rawFinal;
  logic [7:0]             finalCode;
  logic                   winMatch;
  logic                   wrCfg;
  logic                   wrCtrl;
  logic                   wrBusyOne;

  assign wrCfg     = sfrReq.wrEn && sfrReq.addr == CFG_ADDR;
  assign wrCtrl    = sfrReq.wrEn && sfrReq.addr == CTRL_ADDR;
  assign wrBusyOne = wrCtrl && sfrReq.wrData[CTRL_BUSY_BIT];

  // one decision step: keep or drop the bit under trial, then try the next
  function automatic logic [7:0] sarStep(input logic [7:0] code, input logic [2:0] pos,
                                         input logic above);
    logic [7:0] t;
    t = code;
    t[pos] = above;
    if (pos != 3'h0) begin
      t[pos - 3'h1] = 1'b1;
    end
    return t;
  endfunction

  // ****************************************
  // configuration and limit registers
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sarClockDivide <= CFG_RESET[CFG_DIV_LSB +: DIV_BITS];
      ampGainSelect  <= CFG_RESET[CFG_GAIN_LSB +: GAIN_BITS];
    end else if (wrCfg) begin
      sarClockDivide <= sfrReq.wrData[CFG_DIV_LSB +: DIV_BITS];
      ampGainSelect  <= sfrReq.wrData[CFG_GAIN_LSB +: GAIN_BITS];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      windowGreaterLimit <= LIMIT_RESET;
      windowLessLimit    <= LIMIT_RESET;
    end else begin
      if (sfrReq.wrEn && sfrReq.addr == GT_ADDR) begin
        windowGreaterLimit <= sfrReq.wrData;
      end
      if (sfrReq.wrEn && sfrReq.addr == LT_ADDR) begin
        windowLessLimit <= sfrReq.wrData;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      converterEnable <= CTRL_RESET[CTRL_EN_BIT];
      trackModeSelect <= CTRL_RESET[CTRL_TM_BIT];
      startModeSelect <= CTRL_RESET[CTRL_MODE_LSB +: MODE_BITS];
    end else if (wrCtrl) begin
      converterEnable <= sfrReq.wrData[CTRL_EN_BIT];
      trackModeSelect <= sfrReq.wrData[CTRL_TM_BIT];
      startModeSelect <= sfrReq.wrData[CTRL_MODE_LSB +: MODE_BITS];
    end
  end

  // ****************************************
  // sticky flags and result register: a completion, for the window flag a matching one, wins over a write in the same cycle
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      convDoneFlag <= CTRL_RESET[CTRL_DONE_BIT];
    end else if (convFinish) begin
      convDoneFlag <= 1'b1;
    end else if (wrCtrl) begin
      convDoneFlag <= sfrReq.wrData[CTRL_DONE_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      windowMatchFlag <= CTRL_RESET[CTRL_WIN_BIT];
    end else if (convFinish && winMatch) begin
      windowMatchFlag <= 1'b1;
    end else if (wrCtrl) begin
      windowMatchFlag <= sfrReq.wrData[CTRL_WIN_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conversionResult <= RESULT_RESET;
    end else if (convFinish) begin
      conversionResult <= finalCode;
    end else if (sfrReq.wrEn && sfrReq.addr == RESULT_ADDR) begin
      conversionResult <= sfrReq.wrData;
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sfrRdData <= 8'h00;
    end else if (sfrReq.rdEn) begin
      case (sfrReq.addr)
        CFG_ADDR:    sfrRdData <= {sarClockDivide, 1'b0, ampGainSelect};
        CTRL_ADDR:   sfrRdData <= {converterEnable, trackModeSelect, convDoneFlag, busy,
                                   startModeSelect, windowMatchFlag};
        RESULT_ADDR: sfrRdData <= conversionResult;
        GT_ADDR:     sfrRdData <= windowGreaterLimit;
        LT_ADDR:     sfrRdData <= windowLessLimit;
        default:     sfrRdData <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // start sources
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // reset at the pin's idle high level so a high pin gives no false edge
      extMeta <= 1'b1;
      extSync <= 1'b1;
      extPrev <= 1'b1;
    end else begin
      extMeta <= extConvStart;
      extSync <= extMeta;
      extPrev <= extSync;
    end
  end

  assign extRise = extSync && !extPrev;

  always_comb begin
    if (startModeSelect[MODE_SIBLING_BIT]) begin
      trigger = siblingBusyWrite;
    end else begin
      case (startModeSelect)
        MODE_SW:  trigger = wrBusyOne;
        MODE_T3:  trigger = timer3Overflow;
        MODE_EXT: trigger = extRise;
        MODE_T2:  trigger = timer2Overflow;
        default:  trigger = 1'b0;
      endcase
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  assign busy = state != ST_IDLE;

  sar_clock_divider #(
    .WIDTH (DIV_BITS)
  ) uDivider (
    .mclk   (mclk),
    .rst    (rst),
    .run    (busy),
    .divide (sarClockDivide),
    .tick   (sarTick)
  );

  assign convFinish = state == ST_CONV && sarTick && bitPos == 3'h0;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (trigger) begin
          // the pin edge itself ends tracking in low-power pin mode
          if (trackModeSelect && startModeSelect != MODE_EXT) begin
            next_state = ST_TRACK;
          end else begin
            next_state = ST_CONV;
          end
        end
      end
      ST_TRACK: begin
        if (sarTick && trackCnt == 4'h1) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (convFinish) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // disabling aborts a conversion without flagging it
    if (!converterEnable) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trackCnt <= 4'h0;
    end else if (state != ST_TRACK) begin
      trackCnt <= 4'(TRACK_CLOCKS);
    end else if (sarTick) begin
      trackCnt <= trackCnt - 4'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sarTrialCode <= 8'h00;
      bitPos       <= 3'h0;
    end else if (next_state == ST_CONV && state != ST_CONV) begin
      sarTrialCode <= SAR_FIRST_TRIAL;
      bitPos       <= 3'(RESULT_BITS - 1);
    end else if (state == ST_CONV && sarTick) begin
      sarTrialCode <= sarStep(sarTrialCode, bitPos, compAbove);
      bitPos       <= bitPos - 3'h1;
    end
  end

  // ****************************************
  // result format and window
  // ****************************************
  assign diffSel   = channelPairConfig[channelSelect[2:1]];
  assign rawFinal  = sarStep(sarTrialCode, bitPos, compAbove);
  // the core's offset-binary code becomes two's complement by its top bit
  assign finalCode = diffSel ? {~rawFinal[7], rawFinal[6:0]} : rawFinal;

  window_compare uWindow (
    .result       (finalCode),
    .greaterLimit (windowGreaterLimit),
    .lessLimit    (windowLessLimit),
    .signedMode   (diffSel),
    .match        (winMatch)
  );

  assign ampGain      = ampGainSelect;
  assign shutdown     = !converterEnable;
  assign convActive   = state == ST_CONV;
  assign sarConvClock = sarTick;
  assign trackEnable  = converterEnable && (trackModeSelect
                      ? (state == ST_TRACK || (state == ST_IDLE
                         && startModeSelect == MODE_EXT && !extSync))
                      : state == ST_IDLE);

  // ****************************************
  // checks
  // ****************************************
  logic [3:0] trackTicks;
  logic [3:0] convTicks;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trackTicks <= 4'h0;
      convTicks  <= 4'h0;
    end else begin
      trackTicks <= (state != ST_TRACK) ? 4'h0 : trackTicks + 4'(sarTick);
      convTicks  <= (state != ST_CONV) ? 4'h0 : convTicks + 4'(sarTick);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence swStartSeq;
    wrBusyOne && state == ST_IDLE && converterEnable && startModeSelect == MODE_SW;
  endsequence
  sequence extStartSeq;
    !extSync ##1 extSync && state == ST_IDLE && converterEnable
      && startModeSelect == MODE_EXT;
  endsequence

  sw_start_ok_a: assert property (swStartSeq |=> busy)
    else $error("software start not taken");
  sw_start_off_a: assert property ((wrBusyOne && state == ST_IDLE
      && startModeSelect != MODE_SW && !timer3Overflow && !timer2Overflow
      && !extRise && !siblingBusyWrite) |=> !busy)
    else $error("busy write started a conversion");
  ext_start_a: assert property (extStartSeq |=> convActive)
    else $error("pin edge did not start conversion");
  track_len_a: assert property ((state == ST_CONV && $past(state) == ST_TRACK)
      |-> trackTicks == 4'(TRACK_CLOCKS)) else $error("tracking length wrong");
  conv_len_a: assert property (convFinish |-> convTicks == 4'(CONV_CLKS - 1))
    else $error("conversion length wrong");
  done_set_a: assert property (convFinish |=> convDoneFlag && !busy)
    else $error("done flag not set at busy fall");
  done_hold_a: assert property ((convDoneFlag
      && !(wrCtrl && !sfrReq.wrData[CTRL_DONE_BIT])) |=> convDoneFlag)
    else $error("done flag cleared by hardware");
  win_hold_a: assert property ((windowMatchFlag
      && !(wrCtrl && !sfrReq.wrData[CTRL_WIN_BIT])) |=> windowMatchFlag)
    else $error("window flag cleared by hardware");
  win_set_a: assert property ((convFinish && winMatch) |=> windowMatchFlag)
    else $error("window flag not set");
  result_load_a: assert property (convFinish |=> conversionResult == $past(finalCode))
    else $error("result not stored");
  shutdown_idle_a: assert property (!converterEnable |=> !busy)
    else $error("disabled converter busy");
  cfg_bit_zero_a: assert property ((sfrReq.rdEn && sfrReq.addr == CFG_ADDR)
      |=> !sfrRdData[CFG_UNUSED_BIT]) else $error("unused config bit reads one");

endmodule

`default_nettype wire

// ===== design/sar_clock_divider.sv
// conversion clock strobe derived from the system clock
`timescale 1ns/100ps
`default_nettype none

module sar_clock_divider
  import sar_adc8_pkg::*;
#(
  parameter int WIDTH = DIV_BITS
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // control
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] divide,
  // strobe
  output logic                  tick
);

  if (WIDTH < 1) begin : gChk
    $error("divider width must be at least one");
  end

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] sinceTick;

  // held at zero while idle so each conversion starts on a full period
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!run || count == divide) begin
      count <= '0;
    end else begin
      count <= count + WIDTH'(1);
    end
  end

  assign tick = run && (count == divide);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sinceTick <= '0;
    end else if (!run || tick) begin
      sinceTick <= '0;
    end else begin
      sinceTick <= sinceTick + WIDTH'(1);
    end
  end

  tick_period_a: assert property (@(posedge mclk) disable iff (rst)
    tick |-> sinceTick == divide) else $error("conversion clock period wrong");
  tick_gap_a: assert property (@(posedge mclk) disable iff (rst)
    (tick && run && divide != '0) |=> !tick) else $error("back to back strobe");

endmodule

`default_nettype wire

// ===== design/window_compare.sv
// window limit comparison of one conversion result
`timescale 1ns/100ps
`default_nettype none

module window_compare
  import sar_adc8_pkg::*;
(
  // operands
  input  wire logic [7:0] result,
  input  wire logic [7:0] greaterLimit,
  input  wire logic [7:0] lessLimit,
  input  wire logic       signedMode,
  // verdict
  output logic            match
);

  logic aboveGt;
  logic belowLt;
  logic ordered;

  assign aboveGt = isAbove(result, greaterLimit, signedMode);
  assign belowLt = isAbove(lessLimit, result, signedMode);
  // limits in order pick an inside window, otherwise an outside one
  assign ordered = isAbove(lessLimit, greaterLimit, signedMode);
  assign match   = ordered ? (aboveGt && belowLt) : (aboveGt || belowLt);

endmodule

`default_nettype wire

// ===== shared/sar_adc8_pkg.sv
// shared constants, carriers and helpers of the 8-bit converter control
package sar_adc8_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] CFG_ADDR    = 8'hBC;
  localparam logic [7:0] RESULT_ADDR = 8'hBE;
  localparam logic [7:0] CTRL_ADDR   = 8'hE8;
  localparam logic [7:0] GT_ADDR     = 8'hC4;
  localparam logic [7:0] LT_ADDR     = 8'hC6;

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [7:0] CFG_RESET    = 8'hF8;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET  = 8'h00;
  localparam int CFG_DIV_LSB    = 3;
  localparam int CFG_UNUSED_BIT = 2;
  localparam int CFG_GAIN_LSB   = 0;
  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_TM_BIT    = 6;
  localparam int CTRL_DONE_BIT  = 5;
  localparam int CTRL_BUSY_BIT  = 4;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_WIN_BIT   = 0;
  localparam int DIV_BITS       = 5;
  localparam int GAIN_BITS      = 2;
  localparam int MODE_BITS      = 3;
  localparam int RESULT_BITS    = 8;

  // ****************************************
  // start modes and timing
  // ****************************************
  localparam logic [2:0] MODE_SW  = 3'h0;
  localparam logic [2:0] MODE_T3  = 3'h1;
  localparam logic [2:0] MODE_EXT = 3'h2;
  localparam logic [2:0] MODE_T2  = 3'h3;
  localparam int MODE_SIBLING_BIT = 2;
  localparam int LP_TRACK_CLKS    = 3;
  localparam int CONV_CLKS        = 8;
  localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } sfr_req_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONV  = 3'b100
  } conv_state_e;

  // magnitude test under either number format
  function automatic logic isAbove(input logic [7:0] a, input logic [7:0] b,
                                   input logic isSigned);
    if (isSigned) begin
      return $signed(a) > $signed(b);
    end
    return a > b;
  endfunction

endpackage

// ===== tb/cpu_sfr_model.sv
// processor side model issuing register cycles
`timescale 1ns/100ps
`default_nettype none
module cpu_sfr_model
  import sar_adc8_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // register bus
  output sfr_req_s        sfrReq,
  input  wire logic [7:0] sfrRdData
);
  initial sfrReq = '0;
  // an idle bus carries the inverted address, and inverted data after a write, so stale values never match
  task automatic sfrWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfrReq <= '{1'h1, 1'h0, a, d};
    @(posedge mclk);
    sfrReq <= '{1'h0, 1'h0, ~a, ~d};
  endtask
  task automatic sfrRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfrReq <= '{1'h0, 1'h1, a, 8'h00};
    @(posedge mclk);
    sfrReq <= '{1'h0, 1'h0, ~a, 8'hFF};
    #1 d = sfrRdData;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the converter control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sar_adc8_pkg::*;
  // 100 MHz over 17 keeps the conversion clock under 6 MHz
  localparam logic [4:0] DIV = 5'h10;
  localparam int PER = 17;
  localparam logic [2:0] MODES [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  localparam logic [7:0] WGT [6] = '{8'h10, 8'h10, 8'h20, 8'h20, 8'hFF, 8'hFF};
  localparam logic [7:0] WLT [6] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h10, 8'h10};
  localparam logic [3:0] WPAIR [6] = '{4'h0, 4'hE, 4'h0, 4'h0, 4'h1, 4'h1};
  localparam logic [7:0] WCORE [6] = '{8'h15, 8'h20, 8'h05, 8'h15, 8'h85, 8'h90};
  logic mclk, rst, timer3Overflow, timer2Overflow, siblingBusyWrite, extConvStart;
  logic [3:0] channelPairConfig;
  logic [2:0] channelSelect;
  logic [7:0] sfrRdData, sarTrialCode, core, gt, lt, ctrl;
  logic [1:0] ampGain;
  logic trackEnable, convActive, shutdown, sarConvClock;
  sfr_req_s sfrReq;
  int mismatches, compares;
  // analog core model: input sits at the core code
  wire logic compAbove = (core >= sarTrialCode);
  wire logic diffSel = channelPairConfig[channelSelect[2:1]];

  sar_adc8_conversion_control #(.TRACK_CLOCKS(3)) u_sar_adc8_conversion_control (
    .mclk(mclk), .rst(rst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
    .timer3Overflow(timer3Overflow), .timer2Overflow(timer2Overflow),
    .siblingBusyWrite(siblingBusyWrite), .extConvStart(extConvStart),
    .channelPairConfig(channelPairConfig), .channelSelect(channelSelect),
    .compAbove(compAbove), .sarTrialCode(sarTrialCode), .ampGain(ampGain),
    .trackEnable(trackEnable), .convActive(convActive), .shutdown(shutdown),
    .sarConvClock(sarConvClock));
  cpu_sfr_model u_cpu_sfr_model (.mclk(mclk), .sfrReq(sfrReq), .sfrRdData(sfrRdData));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cpu_sfr_model.sfrWrite(a, d);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_cpu_sfr_model.sfrRead(a, d);
    check(d, exp);
  endtask
  task automatic setCtrl(input logic [7:0] v);
    ctrl = v;
    wr(CTRL_ADDR, v);
  endtask
  function automatic logic winExp(input logic [7:0] r);
    int a, g, l;
    a = diffSel ? int'($signed(r)) : int'(r);
    g = diffSel ? int'($signed(gt)) : int'(gt);
    l = diffSel ? int'($signed(lt)) : int'(lt);
    return (g < l) ? (a > g && a < l) : (a < l || a > g);
  endfunction
  // 0 software, 1 timer3, 2 pin, 3 timer2, 4 sibling
  task automatic fire(input int src);
    if (src == 0) begin
      wr(CTRL_ADDR, ctrl | 8'h10);
    end else if (src == 2) begin
      @(posedge mclk);
      extConvStart <= 1'h0;
      repeat (4) @(posedge mclk);
      extConvStart <= 1'h1;
      @(posedge mclk);
    end else begin
      @(posedge mclk);
      timer3Overflow <= (src == 1);
      timer2Overflow <= (src == 3);
      siblingBusyWrite <= (src == 4);
      @(posedge mclk);
      timer3Overflow <= 1'h0;
      timer2Overflow <= 1'h0;
      siblingBusyWrite <= 1'h0;
    end
  endtask
  task automatic runConv(input int src, input int preExp);
    int pre, cnv, strobes, tracked;
    pre = 0;
    cnv = 0;
    strobes = 0;
    tracked = 0;
    fire(src);
    #1;
    while (!convActive && pre < 400) begin
      @(posedge mclk);
      #1;
      pre++;
    end
    check(sarTrialCode, SAR_FIRST_TRIAL);
    while (convActive && cnv < 400) begin
      strobes += int'(sarConvClock);
      tracked += int'(trackEnable);
      @(posedge mclk);
      #1;
      cnv++;
    end
    if (preExp >= 0) check(8'(pre), 8'(preExp));
    check(8'(cnv), 8'(8 * PER));
    check(8'(strobes), 8'h08);
    check(8'(tracked), 8'h00);
    rdChk(RESULT_ADDR, core ^ {diffSel, 7'h00});
    rdChk(CTRL_ADDR, ctrl | 8'h20 | {7'h00, winExp(core ^ {diffSel, 7'h00})});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    #1;
    check({6'h00, ampGain}, 8'h00);
    check({7'h00, shutdown}, 8'h01);
    rdChk(CFG_ADDR, 8'hF8);
    rdChk(CTRL_ADDR, 8'h00);
    rdChk(RESULT_ADDR, 8'h00);
    rdChk(8'hA0, 8'h00);
  endtask
  task automatic t_cfg();
    for (int g = 0; g < 4; g++) begin
      wr(CFG_ADDR, {DIV, 1'h1, 2'(g)});
      rdChk(CFG_ADDR, {DIV, 1'h0, 2'(g)});
      check({6'h00, ampGain}, 8'(g));
    end
    wr(RESULT_ADDR, 8'h3C);
    rdChk(RESULT_ADDR, 8'h3C);
  endtask
  task automatic t_busy();
    core = 8'h00;
    setCtrl(8'h80);
    wr(CTRL_ADDR, 8'h90);
    rdChk(CTRL_ADDR, 8'h90);
    for (int i = 0; i < 400 && convActive; i++) begin
      @(posedge mclk);
      #1;
    end
    repeat (2) @(posedge mclk);
    rdChk(CTRL_ADDR, 8'hA0);
    repeat (20) @(posedge mclk);
    wr(CTRL_ADDR, 8'hA0);
    rdChk(CTRL_ADDR, 8'hA0);
    setCtrl(8'h80);
    rdChk(CTRL_ADDR, 8'h80);
    check({7'h00, trackEnable}, 8'h01);
  endtask
  task automatic t_modes();
    for (int s = 0; s < 5; s++) begin
      setCtrl({4'h8, MODES[s], 1'h0});
      #1;
      check({7'h00, shutdown}, 8'h00);
      core = 8'h31 + 8'(s * 37);
      runConv(s, (s == 2) ? -1 : 0);
    end
  endtask
  task automatic t_refuse();
    setCtrl(8'h82);
    wr(CTRL_ADDR, 8'h92);
    fire(3);
    fire(4);
    repeat (3) @(posedge mclk);
    #1;
    check({7'h00, convActive}, 8'h00);
    rdChk(CTRL_ADDR, 8'h82);
    setCtrl(8'h02);
    fire(1);
    repeat (3) @(posedge mclk);
    #1;
    check({5'h00, trackEnable, convActive, shutdown}, 8'h01);
  endtask
  task automatic t_lowpower();
    setCtrl(8'hC0);
    core = 8'h5A;
    runConv(0, 3 * PER);
    setCtrl(8'hC4);
    @(posedge mclk);
    extConvStart <= 1'h0;
    repeat (8) @(posedge mclk);
    #1;
    check({6'h00, trackEnable, convActive}, 8'h02);
    runConv(2, -1);
  endtask
  task automatic t_window();
    for (int i = 0; i < 6; i++) begin
      gt = WGT[i];
      lt = WLT[i];
      wr(GT_ADDR, gt);
      wr(LT_ADDR, lt);
      channelPairConfig <= WPAIR[i];
      rdChk(GT_ADDR, gt);
      rdChk(LT_ADDR, lt);
      setCtrl(8'h80);
      core = WCORE[i];
      runConv(0, 0);
    end
  endtask

  // ****************************************
  // run control
  // ****************************************
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_sim();
  end
  initial begin
    rst = 1'h1;
    timer3Overflow = 1'h0;
    timer2Overflow = 1'h0;
    siblingBusyWrite = 1'h0;
    extConvStart = 1'h0;
    channelPairConfig = 4'h0;
    channelSelect = 3'h1;
    core = 8'h00;
    gt = 8'h00;
    lt = 8'h00;
    ctrl = 8'h00;
    mismatches = 0;
    compares = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    t_reset();
    t_cfg();
    t_busy();
    t_modes();
    t_refuse();
    t_lowpower();
    t_window();
    end_sim();
  end
endmodule
`default_nettype wire
